// ### core/hie_pkg.sv
// Purpose: Constants for the host interrupt event block (low bits 21..0)
// Assumes: 32-bit Avalon-MM word addressing by byte address
// Notes:   Offsets, field positions and reset values live here
package hie_pkg;
   // ---------------------------------------------------------------
   // Register byte addresses
   // ---------------------------------------------------------------
   localparam logic [7:0] EVT_SET_ADDR   = 8'h80; // Set port, raw read
   localparam logic [7:0] EVT_CLR_ADDR   = 8'h84; // Clear port, masked read
   localparam logic [7:0] MASK_ADDR      = 8'h88; // Enable flags (own map)
   localparam logic [7:0] SRC_CTRL_ADDR  = 8'h90; // Source qualifiers (own map)
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int BIT_SIXTY_FOUR = 21; // Seconds bit 6 changed
   localparam int BIT_NEW_CYCLE  = 20; // Cycle number lsb toggled
   localparam int BIT_PHY_REQ    = 19; // Physical layer request
   localparam int BIT_ACC_FAIL   = 18; // Register access failure
   localparam int BIT_BUS_RESET  = 17; // Bus reset entered
   localparam int BIT_ID_DONE    = 16; // Node id phase done
   localparam int BIT_ID_DONE2   = 15; // Sticky id done copy
   localparam int BIT_LOCK_ERR   = 9;  // Lock reply unacked
   localparam int BIT_POST_ERR   = 8;  // Posted write failure
   localparam int BIT_ISO_RX     = 7;  // Receive summary
   localparam int BIT_ISO_TX     = 6;  // Transmit summary
   localparam int NUM_ISO_CTX    = 8;  // Isochronous contexts per direction
   // Latched event positions: 21..15, 9..8, 5..0
   localparam logic [31:0] LATCHED_MASK = 32'h003f_833f;
   localparam logic [31:0] EVT_RESET    = 32'h0000_0000; // Events after reset
   localparam logic [31:0] MASK_RESET   = 32'h0000_0000; // Enables after reset
   localparam logic [5:0]  QUAL_RESET   = 6'h3f;         // DMA qualifiers on
endpackage

// ### core/hie_event_regs.sv
// Purpose: Host interrupt event register, bits 21 down to 0
// Assumes: Event sources synchronous to ref_clk_i; one clock domain
// Notes:   Set port at 0x80 and clear port at 0x84 over Avalon-MM
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Seconds bit six change sets rollover flag
// - Cycle number lsb toggle sets cycle flag
// - Physical layer status request sets flag
// - Failed access sets flag before next access
// - Bus reset entry sets flag
// - Self-id stream complete sets done flag
// - Bus reset clears done flag same cycle
// - Sticky done set too, bus-reset-immune
// - Bits fourteen to ten read zero
// - Unacked lock reply sets error flag
// - Posted write host error sets flag
// - Receive summary is masked context OR
// - Transmit summary is masked context OR
// - Stored response packet sets flag
// - Stored request packet sets flag
// - Rx response descriptor done sets flag
// - Rx request descriptor done sets flag
// - Response transmit command done sets flag
// - Request transmit command done sets flag
// - Rising source edge or set write sets
// - Only clear-port one write or bus reset (done flag) clears
// - Set reads raw, clear reads masked
module hie_event_regs (
   input  wire logic        ref_clk_i,          // 100 MHz clock
   input  wire logic        reset_i,            // Synchronous reset, high
   input  wire logic        clk_en_i,           // Freezes all state when low
   // Avalon-MM slave
   input  wire logic [7:0]  avs_address_i,      // Byte address
   input  wire logic        avs_read_i,         // Read request
   input  wire logic        avs_write_i,        // Write request
   input  wire logic [31:0] avs_writedata_i,    // Write data
   input  wire logic [3:0]  avs_byteenable_i,   // Byte lanes
   output logic [31:0]      avs_readdata_o,     // Read data
   output logic             avs_waitrequest_o,  // Stall
   // Event sources
   input  wire logic [6:0]  iso_seconds_counter_i, // Seconds count
   input  wire logic [12:0] iso_cycle_number_i,    // Cycle count
   input  wire logic        phy_status_req_i,      // Physical layer request
   input  wire logic        link_clock_present_i,  // Link clock alive
   input  wire logic        bus_reset_state_i,     // In bus reset
   input  wire logic        self_id_received_i,    // Self-id stream done
   input  wire logic        lock_reply_unacked_i,  // Lock reply no ack
   input  wire logic        posted_write_failure_i,// Host bus error
   input  wire logic        response_packet_stored_i, // Rx response stored
   input  wire logic        request_packet_stored_i,  // Rx request stored
   input  wire logic        async_rx_response_dma_i,  // Rx resp descriptor done
   input  wire logic        async_rx_request_dma_i,   // Rx req descriptor done
   input  wire logic        response_send_done_i,     // Tx resp command done
   input  wire logic        request_send_done_i,      // Tx req command done
   input  wire logic [7:0]  iso_rx_event_i,  // Per-context rx events
   input  wire logic [7:0]  iso_rx_mask_i,   // Per-context rx enables
   input  wire logic [7:0]  iso_tx_event_i,  // Per-context tx events
   input  wire logic [7:0]  iso_tx_mask_i,   // Per-context tx enables
   output logic [31:0]      interrupt_event_flags_o, // Event register copy
   output logic             iso_receive_summary_o,   // Registered rx summary
   output logic             iso_transmit_summary_o   // Registered tx summary
);

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   logic [31:0] interrupt_event_flags;  // Latched event bits
   logic [31:0] interrupt_enable_flags; // Mask for clear-port reads
   logic [5:0]  dma_qualify;            // Conditional DMA set enables
   logic [31:0] src_q;                  // Previous source levels
   logic [31:0] src_now;                // Current source levels
   logic [31:0] src_rise;               // Asserting edges
   logic        access_failed;          // Access during missing clock
   logic [31:0] wmask;                  // Byte-lane write mask
   logic        wr_set;                 // Write to set port
   logic        wr_clr;                 // Write to clear port
   logic [7:0]  rx_terms;               // Masked rx contexts
   logic [7:0]  tx_terms;               // Masked tx contexts
   logic        rx_sum;                 // Combinational rx summary
   logic        tx_sum;                 // Combinational tx summary
   logic        ack_pend;               // Request seen, answered next cycle
   logic [31:0] next_flags;             // Next event value

   // ---------------------------------------------------------------
   // Source levels and edges
   // ---------------------------------------------------------------
   // Counter bits are compared with their earlier value, so any change fires
   always_comb begin
      src_now = 32'h0000_0000;
      src_now[hie_pkg::BIT_PHY_REQ]   = phy_status_req_i;
      src_now[hie_pkg::BIT_BUS_RESET] = bus_reset_state_i;
      src_now[hie_pkg::BIT_ID_DONE]   = self_id_received_i;
      src_now[hie_pkg::BIT_ID_DONE2]  = self_id_received_i;
      src_now[hie_pkg::BIT_LOCK_ERR]  = lock_reply_unacked_i;
      src_now[hie_pkg::BIT_POST_ERR]  = posted_write_failure_i;
      src_now[5] = response_packet_stored_i;
      src_now[4] = request_packet_stored_i;
      src_now[3] = async_rx_response_dma_i & dma_qualify[3];
      src_now[2] = async_rx_request_dma_i & dma_qualify[2];
      src_now[1] = response_send_done_i & dma_qualify[1];
      src_now[0] = request_send_done_i & dma_qualify[0];
      src_rise = src_now & ~src_q;
      src_rise[hie_pkg::BIT_SIXTY_FOUR] =
         iso_seconds_counter_i[6] ^ src_q[hie_pkg::BIT_SIXTY_FOUR];
      src_rise[hie_pkg::BIT_NEW_CYCLE] =
         iso_cycle_number_i[0] ^ src_q[hie_pkg::BIT_NEW_CYCLE];
      src_rise[hie_pkg::BIT_ACC_FAIL] = access_failed;
   end

   // Remember source levels for edge detection
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         src_q <= 32'h0000_0000;
      end else if (clk_en_i) begin
         src_q <= src_now;
         src_q[hie_pkg::BIT_SIXTY_FOUR] <= iso_seconds_counter_i[6];
         src_q[hie_pkg::BIT_NEW_CYCLE]  <= iso_cycle_number_i[0];
      end
   end

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   // Each request is answered one cycle after it is first seen
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wmask[b*8 +: 8] = {8{avs_byteenable_i[b]}};
      end
      wr_set = avs_write_i & ~avs_waitrequest_o
               & (avs_address_i == hie_pkg::EVT_SET_ADDR);
      wr_clr = avs_write_i & ~avs_waitrequest_o
               & (avs_address_i == hie_pkg::EVT_CLR_ADDR);
      ack_pend = (avs_read_i | avs_write_i) & avs_waitrequest_o;
      // Access-failure event: any completing access while clock absent
      access_failed = (avs_read_i | avs_write_i) & ~avs_waitrequest_o
                      & ~link_clock_present_i;
   end

   // Waitrequest drops for one cycle to complete each access
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         avs_waitrequest_o <= 1'b1;
      end else if (clk_en_i) begin
         avs_waitrequest_o <= ~ack_pend;
      end
   end

   // ---------------------------------------------------------------
   // Event flag update
   // ---------------------------------------------------------------
   // Sets win over clears so no event is lost on a clear write
   always_comb begin
      next_flags = interrupt_event_flags;
      if (wr_clr) begin
         next_flags = next_flags & ~(avs_writedata_i & wmask);
      end
      next_flags = next_flags | src_rise;
      if (wr_set) begin
         next_flags = next_flags | (avs_writedata_i & wmask);
      end
      if (src_rise[hie_pkg::BIT_BUS_RESET]) begin
         next_flags[hie_pkg::BIT_ID_DONE] = 1'b0;
      end
      next_flags = next_flags & hie_pkg::LATCHED_MASK;
   end

   // Latch the event register
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         interrupt_event_flags <= hie_pkg::EVT_RESET;
      end else if (clk_en_i) begin
         interrupt_event_flags <= next_flags;
      end
   end

   // ---------------------------------------------------------------
   // Mask and qualifier registers
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         interrupt_enable_flags <= hie_pkg::MASK_RESET;
         dma_qualify            <= hie_pkg::QUAL_RESET;
      end else if (clk_en_i && avs_write_i && !avs_waitrequest_o) begin
         if (avs_address_i == hie_pkg::MASK_ADDR) begin
            interrupt_enable_flags <= (interrupt_enable_flags & ~wmask)
                                      | (avs_writedata_i & wmask);
         end
         if (avs_address_i == hie_pkg::SRC_CTRL_ADDR && avs_byteenable_i[0]) begin
            dma_qualify <= avs_writedata_i[5:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // Isochronous summaries, one term per context
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < hie_pkg::NUM_ISO_CTX; g++) begin : g_ctx
         assign rx_terms[g] = iso_rx_event_i[g] & iso_rx_mask_i[g];
         assign tx_terms[g] = iso_tx_event_i[g] & iso_tx_mask_i[g];
      end
   endgenerate
   assign rx_sum = |rx_terms;
   assign tx_sum = |tx_terms;

   // ---------------------------------------------------------------
   // Read data and outputs
   // ---------------------------------------------------------------
   // Summaries are inserted live at read time, never stored in flags
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (clk_en_i) begin
         if (ack_pend && avs_read_i) begin
            unique case (avs_address_i)
               hie_pkg::EVT_SET_ADDR: begin
                  avs_readdata_o <= interrupt_event_flags
                                    | ({31'h0, rx_sum} << hie_pkg::BIT_ISO_RX)
                                    | ({31'h0, tx_sum} << hie_pkg::BIT_ISO_TX);
               end
               hie_pkg::EVT_CLR_ADDR: begin
                  avs_readdata_o <= (interrupt_event_flags
                                    | ({31'h0, rx_sum} << hie_pkg::BIT_ISO_RX)
                                    | ({31'h0, tx_sum} << hie_pkg::BIT_ISO_TX))
                                    & interrupt_enable_flags;
               end
               hie_pkg::MASK_ADDR: begin
                  avs_readdata_o <= interrupt_enable_flags;
               end
               hie_pkg::SRC_CTRL_ADDR: begin
                  avs_readdata_o <= {26'h0, dma_qualify};
               end
               default: begin
                  avs_readdata_o <= 32'h0000_0000; // Unmapped reads zero
               end
            endcase
         end
      end
   end

   // Registered copies of the flags and summaries
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         interrupt_event_flags_o <= 32'h0000_0000;
         iso_receive_summary_o   <= 1'b0;
         iso_transmit_summary_o  <= 1'b0;
      end else if (clk_en_i) begin
         interrupt_event_flags_o <= next_flags;
         iso_receive_summary_o   <= rx_sum;
         iso_transmit_summary_o  <= tx_sum;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   sequence s_reset_rise;
      clk_en_i && !reset_i && bus_reset_state_i && !src_q[hie_pkg::BIT_BUS_RESET];
   endsequence

   property p_reset_clears_done;
      @(posedge ref_clk_i) disable iff (reset_i)
      s_reset_rise |=> interrupt_event_flags[hie_pkg::BIT_BUS_RESET]
                       && !interrupt_event_flags[hie_pkg::BIT_ID_DONE];
   endproperty
   a_reset_clears_done: assert property (p_reset_clears_done)
      else $error("done flag not cleared by bus reset");

   property p_sticky_kept;
      @(posedge ref_clk_i) disable iff (reset_i)
      (interrupt_event_flags[hie_pkg::BIT_ID_DONE2] && !wr_clr)
      |=> interrupt_event_flags[hie_pkg::BIT_ID_DONE2];
   endproperty
   a_sticky_kept: assert property (p_sticky_kept)
      else $error("sticky done flag lost");

   property p_reserved_zero;
      @(posedge ref_clk_i) disable iff (reset_i)
      !avs_waitrequest_o |-> avs_readdata_o[14:10] == 5'h00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved bits not zero");

   property p_cycle_toggle;
      @(posedge ref_clk_i) disable iff (reset_i)
      (clk_en_i && (iso_cycle_number_i[0] != src_q[hie_pkg::BIT_NEW_CYCLE]))
      |=> interrupt_event_flags[hie_pkg::BIT_NEW_CYCLE];
   endproperty
   a_cycle_toggle: assert property (p_cycle_toggle)
      else $error("cycle flag not set on toggle");

   property p_clear_only;
      @(posedge ref_clk_i) disable iff (reset_i)
      (clk_en_i && interrupt_event_flags[hie_pkg::BIT_LOCK_ERR]
       && !(wr_clr && avs_writedata_i[hie_pkg::BIT_LOCK_ERR] && avs_byteenable_i[1]))
      |=> interrupt_event_flags[hie_pkg::BIT_LOCK_ERR];
   endproperty
   a_clear_only: assert property (p_clear_only)
      else $error("flag cleared without clear write");

   property p_set_write;
      @(posedge ref_clk_i) disable iff (reset_i)
      (clk_en_i && wr_set && avs_writedata_i[0] && avs_byteenable_i[0])
      |=> interrupt_event_flags[0];
   endproperty
   a_set_write: assert property (p_set_write)
      else $error("set write ignored");

   property p_fail_before_next;
      @(posedge ref_clk_i) disable iff (reset_i)
      (clk_en_i && access_failed) |=> interrupt_event_flags[hie_pkg::BIT_ACC_FAIL];
   endproperty
   a_fail_before_next: assert property (p_fail_before_next)
      else $error("access failure not flagged");

   property p_rx_summary;
      @(posedge ref_clk_i) disable iff (reset_i)
      clk_en_i |=> iso_receive_summary_o == $past(|(iso_rx_event_i & iso_rx_mask_i));
   endproperty
   a_rx_summary: assert property (p_rx_summary)
      else $error("rx summary wrong");

   property p_tx_summary;
      @(posedge ref_clk_i) disable iff (reset_i)
      clk_en_i |=> iso_transmit_summary_o == $past(|(iso_tx_event_i & iso_tx_mask_i));
   endproperty
   a_tx_summary: assert property (p_tx_summary)
      else $error("tx summary wrong");

   // Seconds bit change latches the rollover flag on the next edge
   property p_rollover;
      @(posedge ref_clk_i) disable iff (reset_i)
      (clk_en_i && (iso_seconds_counter_i[6] != src_q[hie_pkg::BIT_SIXTY_FOUR]))
      |=> interrupt_event_flags[hie_pkg::BIT_SIXTY_FOUR];
   endproperty
   a_rollover: assert property (p_rollover)
      else $error("rollover flag not set on change");

   // Level sources latch on their rising edge
   property p_phy_req;
      @(posedge ref_clk_i) disable iff (reset_i)
      (clk_en_i && phy_status_req_i && !src_q[hie_pkg::BIT_PHY_REQ])
      |=> interrupt_event_flags[hie_pkg::BIT_PHY_REQ];
   endproperty
   a_phy_req: assert property (p_phy_req)
      else $error("physical layer request not flagged");

   property p_lock_set;
      @(posedge ref_clk_i) disable iff (reset_i)
      (clk_en_i && lock_reply_unacked_i && !src_q[hie_pkg::BIT_LOCK_ERR])
      |=> interrupt_event_flags[hie_pkg::BIT_LOCK_ERR];
   endproperty
   a_lock_set: assert property (p_lock_set)
      else $error("lock reply error not flagged");

   property p_sticky_set;
      @(posedge ref_clk_i) disable iff (reset_i)
      (clk_en_i && self_id_received_i && !src_q[hie_pkg::BIT_ID_DONE2])
      |=> interrupt_event_flags[hie_pkg::BIT_ID_DONE2];
   endproperty
   a_sticky_set: assert property (p_sticky_set)
      else $error("sticky done flag not set");

   // A clear-port read shows no bit outside the enable flags
   sequence s_clr_read;
      clk_en_i && avs_read_i && avs_waitrequest_o
      && (avs_address_i == hie_pkg::EVT_CLR_ADDR);
   endsequence

   property p_masked_read;
      @(posedge ref_clk_i) disable iff (reset_i)
      s_clr_read |=> (avs_readdata_o & ~$past(interrupt_enable_flags)) == 32'h0000_0000;
   endproperty
   a_masked_read: assert property (p_masked_read)
      else $error("clear-port read shows masked bits");

endmodule
`default_nettype wire

// ### testbench/host_interrupt_event_low_bits_tb.sv
// Purpose: Self-checking bench for the host interrupt event block, bits 21..0
// Assumes: One 100 MHz clock; bench acts as Avalon-MM master with full handshake
// Notes:   Event sources are pulsed singly, four DMA ones together in t_qual, and judged through bus reads
`timescale 1ns/100ps
`default_nettype none
module host_interrupt_event_low_bits_tb;
   // ------------------------------------------------------------
   // Stimulus and observation signals
   // ------------------------------------------------------------
   logic        ref_clk_i    = 1'h0;     // Bench clock
   logic        reset_i      = 1'h1;     // Held high at start
   logic [7:0]  adr          = 8'h00;    // Bus address
   logic        rd           = 1'h0;     // Read request
   logic        wr           = 1'h0;     // Write request
   logic [31:0] wdat         = 32'h0;    // Write data
   logic [3:0]  be           = 4'hf;     // Byte lanes
   logic [6:0]  secs         = 7'h00;    // Seconds count source
   logic [12:0] cyc          = 13'h0000; // Cycle count source
   logic        link_ok      = 1'h1;     // Link clock present
   logic        en           = 1'h1;     // Clock enable
   logic [10:0] ev           = 11'h000;  // Single-bit event sources
   logic [7:0]  rxe          = 8'h00;    // Rx context events
   logic [7:0]  rxm          = 8'h00;    // Rx context enables
   logic [7:0]  txe          = 8'h00;    // Tx context events
   logic [7:0]  txm          = 8'h00;    // Tx context enables
   logic [31:0] rdat_o;                  // Read data from design
   logic        wait_o;                  // Waitrequest from design
   logic [31:0] flags_o;                 // Event register copy
   logic        rx_sum_o;                // Rx summary
   logic        tx_sum_o;                // Tx summary
   logic [31:0] got;                     // Last read data
   int          bad_count    = 0;        // Mismatches
   int          total_checks = 0;        // Comparisons made
   // Expected flags for each ev bit, in ev order
   logic [31:0] exp_tab [0:10] = '{32'h1, 32'h2, 32'h4, 32'h8, 32'h10, 32'h20,
      32'h100, 32'h200, 32'h18000, 32'h20000, 32'h80000};

   // Clock toggles every half period
   always #5 ref_clk_i = ~ref_clk_i;

   // ------------------------------------------------------------
   // Design under test
   // ------------------------------------------------------------
   hie_event_regs u_dut (
      .ref_clk_i(ref_clk_i), .reset_i(reset_i), .clk_en_i(en),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wdat), .avs_byteenable_i(be),
      .avs_readdata_o(rdat_o), .avs_waitrequest_o(wait_o),
      .iso_seconds_counter_i(secs), .iso_cycle_number_i(cyc),
      .phy_status_req_i(ev[10]), .link_clock_present_i(link_ok),
      .bus_reset_state_i(ev[9]), .self_id_received_i(ev[8]),
      .lock_reply_unacked_i(ev[7]), .posted_write_failure_i(ev[6]),
      .response_packet_stored_i(ev[5]), .request_packet_stored_i(ev[4]),
      .async_rx_response_dma_i(ev[3]), .async_rx_request_dma_i(ev[2]),
      .response_send_done_i(ev[1]), .request_send_done_i(ev[0]),
      .iso_rx_event_i(rxe), .iso_rx_mask_i(rxm), .iso_tx_event_i(txe),
      .iso_tx_mask_i(txm), .interrupt_event_flags_o(flags_o),
      .iso_receive_summary_o(rx_sum_o), .iso_transmit_summary_o(tx_sum_o));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   // Compare and count
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask
   // One bus cycle; held until waitrequest is seen low, watchdog ends a hang
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] b);
      @(posedge ref_clk_i);
      adr <= a;
      wdat <= d;
      be <= b;
      wr <= w;
      rd <= ~w;
      do begin
         @(posedge ref_clk_i);
      end while (wait_o !== 1'h0);
      got = rdat_o;
      wr <= 1'h0;
      rd <= 1'h0;
   endtask
   // Read the raw set port
   task automatic rd_raw(input logic [31:0] e);
      bus(1'h0, hie_pkg::EVT_SET_ADDR, 32'h0, 4'hf);
      chk(got, e);
   endtask
   // Clear every latched flag
   task automatic clr_all;
      bus(1'h1, hie_pkg::EVT_CLR_ADDR, 32'hffff_ffff, 4'hf);
   endtask
   // One-cycle pulse on chosen sources
   task automatic pulse(input logic [10:0] m);
      @(posedge ref_clk_i);
      ev <= m;
      @(posedge ref_clk_i);
      ev <= 11'h000;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   // Reset contents and an unmapped address
   task automatic t_reset;
      rd_raw(32'h0);
      bus(1'h0, hie_pkg::MASK_ADDR, 32'h0, 4'hf);
      chk(got, 32'h0);
      bus(1'h0, hie_pkg::SRC_CTRL_ADDR, 32'h0, 4'hf);
      chk(got, 32'h3f);
      bus(1'h1, 8'ha0, 32'hffff_ffff, 4'hf);
      bus(1'h0, 8'ha0, 32'h0, 4'hf);
      chk(got, 32'h0);
   endtask
   // Each single-bit source sets only its own flag, self-id sets both done flags
   task automatic t_sources;
      for (int i = 0; i < 11; i++) begin
         pulse(11'h001 << i);
         rd_raw(exp_tab[i]);
         chk(flags_o, exp_tab[i]);
         clr_all();
         rd_raw(32'h0);
         chk(flags_o, 32'h0);
      end
   endtask
   // Only seconds bit six and cycle lsb changes count, either direction
   task automatic t_counters;
      @(posedge ref_clk_i);
      secs <= 7'h3f;
      cyc <= 13'h0002;
      rd_raw(32'h0);
      secs <= 7'h40;
      cyc <= 13'h0003;
      rd_raw(32'h0030_0000);
      clr_all();
      secs <= 7'h00;
      cyc <= 13'h0002;
      rd_raw(32'h0030_0000);
      clr_all();
   endtask
   // Bus reset drops the done flag but not its sticky copy
   task automatic t_pair_id;
      pulse(11'h100);
      pulse(11'h200);
      rd_raw(32'h0002_8000);
      bus(1'h1, hie_pkg::EVT_CLR_ADDR, 32'h0002_0000, 4'hf);
      rd_raw(32'h0000_8000);
      clr_all();
   endtask
   // Access without link clock flags a failure before the next access
   task automatic t_access_fail;
      @(posedge ref_clk_i);
      link_ok <= 1'h0;
      bus(1'h0, hie_pkg::MASK_ADDR, 32'h0, 4'hf);
      link_ok <= 1'h1;
      rd_raw(32'h0004_0000);
      clr_all();
   endtask
   // Set and clear ports, zero writes, reserved bits and byte lanes
   task automatic t_setclr;
      bus(1'h1, hie_pkg::EVT_SET_ADDR, 32'hffff_ffff, 4'hf);
      rd_raw(hie_pkg::LATCHED_MASK);
      bus(1'h1, hie_pkg::EVT_CLR_ADDR, 32'h0, 4'hf);
      bus(1'h1, hie_pkg::EVT_SET_ADDR, 32'h0, 4'hf);
      rd_raw(hie_pkg::LATCHED_MASK);
      bus(1'h1, hie_pkg::EVT_CLR_ADDR, 32'hffff_ffff, 4'h1);
      rd_raw(32'h003f_8300);
      clr_all();
      bus(1'h1, hie_pkg::EVT_SET_ADDR, 32'hffff_ffff, 4'h4);
      rd_raw(32'h003f_0000);
      clr_all();
   endtask
   // Clear port reads masked, set port reads raw
   task automatic t_mask;
      bus(1'h1, hie_pkg::EVT_SET_ADDR, 32'h003f_833f, 4'hf);
      bus(1'h1, hie_pkg::MASK_ADDR, 32'h0005_0101, 4'hf);
      bus(1'h0, hie_pkg::EVT_CLR_ADDR, 32'h0, 4'hf);
      chk(got, 32'h0005_0101);
      rd_raw(32'h003f_833f);
      bus(1'h1, hie_pkg::MASK_ADDR, 32'h0, 4'hf);
      clr_all();
   endtask
   // Summaries follow masked context events and cannot be cleared
   task automatic t_iso;
      @(posedge ref_clk_i);
      rxe <= 8'h10;
      txm <= 8'h80;
      rd_raw(32'h0);
      rxm <= 8'h10;
      txe <= 8'h80;
      rd_raw(32'h0000_00c0);
      chk({30'h0, rx_sum_o, tx_sum_o}, 32'h3);
      clr_all();
      rd_raw(32'h0000_00c0);
      bus(1'h1, hie_pkg::MASK_ADDR, 32'h0000_0040, 4'hf);
      bus(1'h0, hie_pkg::EVT_CLR_ADDR, 32'h0, 4'hf);
      chk(got, 32'h0000_0040);
      rxe <= 8'h00;
      txe <= 8'h00;
      rd_raw(32'h0);
      chk({30'h0, rx_sum_o, tx_sum_o}, 32'h0);
      bus(1'h1, hie_pkg::MASK_ADDR, 32'h0, 4'hf);
   endtask
   // DMA completions latch only where their qualifier is on
   task automatic t_qual;
      bus(1'h1, hie_pkg::SRC_CTRL_ADDR, 32'h05, 4'hf);
      pulse(11'h00f);
      rd_raw(32'h5);
      clr_all();
      bus(1'h1, hie_pkg::SRC_CTRL_ADDR, 32'h3f, 4'hf);
      pulse(11'h00f);
      rd_raw(32'hf);
      clr_all();
   endtask

   // A low clock enable freezes state, so a pulse meanwhile is lost
   task automatic t_freeze;
      @(posedge ref_clk_i);
      en <= 1'h0;
      pulse(11'h400);
      en <= 1'h1;
      rd_raw(32'h0);
      chk(flags_o, 32'h0);
   endtask

   // ------------------------------------------------------------
   // Verdict, main sequence and watchdog
   // ------------------------------------------------------------
   task automatic give_verdict;
      if (bad_count == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (12) @(posedge ref_clk_i);
      reset_i <= 1'h0;
      t_reset();
      t_sources();
      t_counters();
      t_pair_id();
      t_access_fail();
      t_setclr();
      t_mask();
      t_iso();
      t_qual();
      t_freeze();
      give_verdict();
   end

   // Watchdog well past the expected few hundred cycles
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      bad_count++;
      give_verdict();
   end
endmodule
`default_nettype wire
